// *** logic/ibh_holdoff.sv ***
module ibh_holdoff
    import ibh_pkg::*;
(
    input wire logic CLK_I,                  // 20 MHz clock
    input wire logic NRST_I,                 // Async reset, active low
    input wire logic TERM_RX_I,              // Terminator byte received (pin side)
    input wire logic TALK_ADDR_I,            // Addressed to talk (pin side)
    input wire logic BYTE_SENT_I,            // One response byte taken (pin side)
    input wire logic SPOLL_I,                // Serial poll in progress (pin side)
    input wire logic LOCAL_KEY_I,            // Front-panel local key (pin side)
    input wire ibh_buscmd_type BUSCMD_I,     // Bus commands (pin side)
    input wire logic NDAC_HOLD_EN_I,         // Data-accepted hold-off option
    input wire logic NDAC_HOLD_WR_I,         // Option write strobe
    input wire logic RQS_I,                  // Service request wanted
    input wire ibh_engine_type ENGINE_I,     // Command engine status
    output logic NRFD_HOLD_O,                // Hold not-ready-for-data
    output logic NDAC_HOLD_O,                // Hold not-data-accepted
    output logic NDAC_OPTION_O,              // Option state
    output logic MAV_O,                      // Message-available poll bit
    output logic SRQ_O,                      // Service request line drive
    output logic FORMAT_REQ_O,               // Start formatting response
    output logic AUTO_READ_O,                // Implied read query pulse
    output logic TRIGGER_O,                  // Trigger pulse to engine
    output logic PARSER_RESET_O,             // Reset parser, drop query
    output logic REMOTE_INDICATOR_O,         // Remote indicator
    output logic LISTENER_INDICATOR_O,       // Listen indicator, held off
    output logic TALK_INDICATOR_O,           // Talk indicator, held off
    output logic SRQ_INDICATOR_O,            // Service request indicator, held off
    output logic LOCKOUT_O                   // Local lockout state
);
    logic term_s, talk_s, sent_s, spoll_s, key_s;
    ibh_buscmd_type cmd_s;
    ibh_state_type state, next_state;
    logic talk_d, key_d, get_d;
    logic query_pending, formatted;
    logic clear_ev, talk_rise, remote;

    // Pin inputs through two flops
    ibh_sync #(.WIDTH(11)) u_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .d_i({TERM_RX_I, TALK_ADDR_I, BYTE_SENT_I, SPOLL_I, LOCAL_KEY_I, BUSCMD_I}),
        .q_o({term_s, talk_s, sent_s, spoll_s, key_s, cmd_s})
    );

    assign clear_ev = cmd_s.ifc | cmd_s.dcl;
    assign talk_rise = talk_s & ~talk_d;

    // Edge history
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            talk_d <= 1'b0;
            key_d <= 1'b0;
            get_d <= 1'b0;
        end else begin
            talk_d <= talk_s;
            key_d <= key_s;
            get_d <= cmd_s.get;
        end
    end

    // Hold-off sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_LISTEN: begin
                if (term_s) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ENGINE_I.cmd_done | ENGINE_I.cmd_error | ENGINE_I.acq_start) begin
                    next_state = ST_TALK;
                end
            end
            ST_TALK: begin
                next_state = ST_LISTEN;
            end
            default: begin
                next_state = ST_LISTEN;
            end
        endcase
        if (clear_ev) begin
            next_state = ST_LISTEN;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= ST_LISTEN;
        end else begin
            state <= next_state;
        end
    end

    // Ready-for-data hold follows the sequencer, independent of option
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            NRFD_HOLD_O <= 1'b0;
        end else begin
            NRFD_HOLD_O <= (next_state == ST_HOLD);
        end
    end

    // Data-accepted hold-off option
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            NDAC_OPTION_O <= NDAC_HOLD_RESET;
        end else if (NDAC_HOLD_WR_I) begin
            NDAC_OPTION_O <= NDAC_HOLD_EN_I;
        end
    end

    // Data-accepted hold while command runs
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            NDAC_HOLD_O <= 1'b0;
        end else begin
            NDAC_HOLD_O <= NDAC_OPTION_O & (next_state == ST_HOLD);
        end
    end

    // Pending query tracking; set wins over clear
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            query_pending <= 1'b0;
        end else if (ENGINE_I.query_seen) begin
            query_pending <= 1'b1;
        end else if (clear_ev) begin
            query_pending <= 1'b0;
        end else if (sent_s & ~talk_s & formatted) begin
            query_pending <= 1'b0;
        end
    end

    // Message available at query completion
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            MAV_O <= 1'b0;
        end else if (ENGINE_I.query_done) begin
            MAV_O <= 1'b1;
        end else if (clear_ev | (formatted & talk_rise)) begin
            MAV_O <= 1'b0;
        end
    end

    // Formatting deferred to first talk; later talks continue
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            formatted <= 1'b0;
            FORMAT_REQ_O <= 1'b0;
        end else begin
            FORMAT_REQ_O <= talk_rise & query_pending & ~formatted & ~clear_ev;
            if (clear_ev | ENGINE_I.query_seen) begin
                formatted <= 1'b0;
            end else if (talk_rise & query_pending) begin
                formatted <= 1'b1;
            end
        end
    end

    // Implied read on talk with no query
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AUTO_READ_O <= 1'b0;
        end else begin
            AUTO_READ_O <= talk_rise & ~query_pending & ~clear_ev;
        end
    end

    // Trigger pulse on get rising edge; parser reset follows the clear level
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            TRIGGER_O <= 1'b0;
            PARSER_RESET_O <= 1'b0;
        end else begin
            TRIGGER_O <= cmd_s.get & ~get_d;
            PARSER_RESET_O <= clear_ev;
        end
    end

    // Service request, dropped during poll
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SRQ_O <= 1'b0;
        end else begin
            SRQ_O <= RQS_I & ~spoll_s;
        end
    end

    // Remote and lockout state
    assign remote = REMOTE_INDICATOR_O;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            REMOTE_INDICATOR_O <= 1'b0;
            LOCKOUT_O <= 1'b0;
        end else begin
            if (!cmd_s.ren) begin
                LOCKOUT_O <= 1'b0;
            end else if (cmd_s.gtl) begin
                LOCKOUT_O <= 1'b0;
            end else if (cmd_s.llo) begin
                LOCKOUT_O <= 1'b1;
            end
            if (!cmd_s.ren) begin
                REMOTE_INDICATOR_O <= 1'b0;
            end else if (key_s & ~key_d & ~LOCKOUT_O) begin
                REMOTE_INDICATOR_O <= 1'b0;
            end else if (term_s | talk_rise) begin
                REMOTE_INDICATOR_O <= 1'b1;
            end else begin
                REMOTE_INDICATOR_O <= remote;
            end
        end
    end

    // Disabled indicators
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            LISTENER_INDICATOR_O <= 1'b0;
            TALK_INDICATOR_O <= 1'b0;
            SRQ_INDICATOR_O <= 1'b0;
        end else begin
            LISTENER_INDICATOR_O <= 1'b0;
            TALK_INDICATOR_O <= 1'b0;
            SRQ_INDICATOR_O <= 1'b0;
        end
    end

    // Checks
    a_hold_on_term: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (state == ST_LISTEN && term_s && !clear_ev) |=> NRFD_HOLD_O)
        else $error("hold not raised on terminator");
    a_hold_release: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (state == ST_HOLD && (ENGINE_I.cmd_done || ENGINE_I.cmd_error)) |=> !NRFD_HOLD_O)
        else $error("hold not released");
    a_acq_release: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (state == ST_HOLD && ENGINE_I.acq_start) |=> !NRFD_HOLD_O)
        else $error("acquisition did not release hold");
    a_ndac_gated: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        NDAC_HOLD_O |-> ($past(NDAC_OPTION_O) && NRFD_HOLD_O))
        else $error("ndac hold without option");
    a_option_reset: assert property (@(posedge CLK_I)
        $rose(NRST_I) |-> !NDAC_OPTION_O)
        else $error("option not off after reset");
    a_auto_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (talk_rise && !query_pending && !clear_ev) |=> AUTO_READ_O ##1 !AUTO_READ_O)
        else $error("no implied read");
    a_mav_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        ENGINE_I.query_done |=> MAV_O)
        else $error("mav not set");
    a_clear_release: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        clear_ev |=> (!NRFD_HOLD_O && !NDAC_HOLD_O && PARSER_RESET_O))
        else $error("clear did not release");
    a_ind_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        $past(NRST_I) |-> !(LISTENER_INDICATOR_O || TALK_INDICATOR_O))
        else $error("indicator driven");
    a_gtl_lockout: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        cmd_s.gtl |=> !LOCKOUT_O)
        else $error("gtl kept lockout");
    c_hold: cover property (@(posedge CLK_I) disable iff (!NRST_I)
        NRFD_HOLD_O ##[1:20] !NRFD_HOLD_O);
    c_ndac: cover property (@(posedge CLK_I) disable iff (!NRST_I) NDAC_HOLD_O);
    c_auto: cover property (@(posedge CLK_I) disable iff (!NRST_I) AUTO_READ_O);
    c_fmt: cover property (@(posedge CLK_I) disable iff (!NRST_I) FORMAT_REQ_O);
endmodule : ibh_holdoff

// *** logic/ibh_pkg.sv ***
package ibh_pkg;
    // Bus message kinds decoded from the interface layer
    typedef struct packed {
        logic ifc;   // Interface clear
        logic dcl;   // Device or selected device clear
        logic get;   // Group execute trigger
        logic llo;   // Local lockout
        logic gtl;   // Go to local
        logic ren;   // Remote enable level
    } ibh_buscmd_type;

    // Command engine status toward the bus logic
    typedef struct packed {
        logic cmd_done;     // All commands of message finished
        logic cmd_error;    // Parser or command error
        logic acq_start;    // Message started acquisition
        logic query_done;   // Query processing complete
        logic query_seen;   // Message held a query
    } ibh_engine_type;

    // Hold-off sequencer states, Gray from ST_LISTEN to ST_TALK; ST_IDLE is never entered
    typedef enum logic [1:0] {
        ST_LISTEN = 2'b00,
        ST_HOLD   = 2'b01,
        ST_TALK   = 2'b11,
        ST_IDLE   = 2'b10
    } ibh_state_type;

    localparam logic NDAC_HOLD_RESET = 1'b0;
    localparam logic [1:0] SYNC_STAGES = 2'h2;
endpackage : ibh_pkg

// *** logic/ibh_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
module ibh_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,              // Clock
    input wire logic nrst_i,             // Async reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Async level
    output logic [WIDTH-1:0] q_o         // Synchronised level
);
    logic [WIDTH-1:0] meta;

    // Only the second stage reads the first
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : ibh_sync

// *** tb/ibh_ctrl_model.sv ***
// Bus controller model driving the pin side of the port
module ibh_ctrl_model
    import ibh_pkg::*;
(
    input wire logic clk_i, // Bench clock
    output logic term_o, // Terminator seen
    output logic talk_o, // Talk addressed
    output logic sent_o, // Byte taken
    output logic spoll_o, // Serial poll
    output ibh_buscmd_type cmd_o // Bus commands
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        term_o = 1'b0;
        talk_o = 1'b0;
        sent_o = 1'b0;
        spoll_o = 1'b0;
        cmd_o = '0;
    end
    // One query alone per message, then the terminator; no talk before it
    task automatic send_term();
        @(negedge clk_i);
        term_o = 1'b1;
        @(negedge clk_i);
        term_o = 1'b0;
    endtask : send_term
    // Source output assumed on before any reading request
    task automatic set_talk(input logic v);
        @(negedge clk_i);
        talk_o = v;
    endtask : set_talk
    // Accept response bytes one per two cycles
    task automatic take_bytes(input int n);
        repeat (n) begin
            @(negedge clk_i);
            sent_o = 1'b1;
            @(negedge clk_i);
            sent_o = 1'b0;
        end
    endtask : take_bytes
    // Bus command levels
    task automatic set_cmd(input ibh_buscmd_type v);
        @(negedge clk_i);
        cmd_o = v;
    endtask : set_cmd
    // Serial poll level
    task automatic set_poll(input logic v);
        @(negedge clk_i);
        spoll_o = v;
    endtask : set_poll
endmodule : ibh_ctrl_model

// *** tb/instrument_bus_holdoff_talk_logic_tb.sv ***
module instrument_bus_holdoff_talk_logic_tb
    import ibh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, term, talk, sent, spoll, lkey, nd_en, nd_wr, rqs;
    logic nrfd, ndac, opt, mav, srq, fmt, auto_rd, trig, prst, remote_indicator, lsn, tki, sri, lock;
    ibh_buscmd_type bcmd;
    ibh_engine_type eng;
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] fmt_cnt = 8'h00;
    logic [7:0] auto_cnt = 8'h00;
    logic [7:0] ind_bad = 8'h00;
    wire logic [10:0] outs = {lock, remote_indicator, prst, trig, auto_rd, fmt, mav, srq, opt, ndac, nrfd};

    ibh_ctrl_model i_ibh_ctrl_model (.clk_i(clk), .term_o(term), .talk_o(talk),
        .sent_o(sent), .spoll_o(spoll), .cmd_o(bcmd));
    ibh_holdoff i_ibh_holdoff (.CLK_I(clk), .NRST_I(nrst), .TERM_RX_I(term),
        .TALK_ADDR_I(talk), .BYTE_SENT_I(sent), .SPOLL_I(spoll), .LOCAL_KEY_I(lkey),
        .BUSCMD_I(bcmd), .NDAC_HOLD_EN_I(nd_en), .NDAC_HOLD_WR_I(nd_wr), .RQS_I(rqs),
        .ENGINE_I(eng), .NRFD_HOLD_O(nrfd), .NDAC_HOLD_O(ndac), .NDAC_OPTION_O(opt),
        .MAV_O(mav), .SRQ_O(srq), .FORMAT_REQ_O(fmt), .AUTO_READ_O(auto_rd),
        .TRIGGER_O(trig), .PARSER_RESET_O(prst), .REMOTE_INDICATOR_O(remote_indicator),
        .LISTENER_INDICATOR_O(lsn), .TALK_INDICATOR_O(tki), .SRQ_INDICATOR_O(sri),
        .LOCKOUT_O(lock));

    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pulse counters and indicator watch
    always @(posedge clk) begin
        if (fmt === 1'b1) fmt_cnt <= fmt_cnt + 8'h01;
        if (auto_rd === 1'b1) auto_cnt <= auto_cnt + 8'h01;
        if (nrst && {lsn, tki, sri} !== 3'h0) ind_bad <= ind_bad + 8'h01;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Bounded wait for one output bit, then compare
    task automatic wait_bit(input int idx, input logic v, input int max);
        int n;
        n = 0;
        while (outs[idx] !== v && n < max) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, outs[idx]}, {7'h00, v});
    endtask : wait_bit
    task automatic eng_pulse(input logic [4:0] v);
        @(negedge clk);
        eng = ibh_engine_type'(v);
        @(negedge clk);
        eng = '0;
    endtask : eng_pulse
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    // Hold-off set by terminator, released by done, error or acquisition start
    task automatic t_release();
        logic [4:0] kinds [3] = '{5'h10, 5'h08, 5'h04};
        foreach (kinds[k]) begin
            i_ibh_ctrl_model.send_term();
            wait_bit(0, 1'b1, 6);
            i_ibh_ctrl_model.send_term();
            repeat (5) @(negedge clk);
            chk({7'h00, nrfd}, 8'h01);
            eng_pulse(kinds[k]);
            @(negedge clk);
            chk({7'h00, nrfd}, 8'h00);
        end
        i_ibh_ctrl_model.set_cmd(6'h08);
        wait_bit(7, 1'b1, 6);
        @(negedge clk);
        chk({7'h00, trig}, 8'h00);
        i_ibh_ctrl_model.set_cmd(6'h00);
    endtask : t_release
    // Data-accepted option on then off, then cleared by a mid-run reset
    task automatic t_ndac();
        for (int v = 1; v >= 0; v--) begin
            @(negedge clk);
            nd_en = v[0];
            nd_wr = 1'b1;
            @(negedge clk);
            nd_wr = 1'b0;
            @(negedge clk);
            chk({7'h00, opt}, {7'h00, v[0]});
            i_ibh_ctrl_model.send_term();
            wait_bit(0, 1'b1, 6);
            chk({7'h00, ndac}, {7'h00, v[0]});
            eng_pulse(5'h10);
            @(negedge clk);
            chk({6'h00, ndac, nrfd}, 8'h00);
        end
        @(negedge clk);
        nd_en = 1'b1;
        nd_wr = 1'b1;
        @(negedge clk);
        nd_wr = 1'b0;
        chk({7'h00, opt}, 8'h01);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk({7'h00, opt}, 8'h00);
    endtask : t_ndac
    // Query, message available, deferred format, repeated talk
    task automatic t_query();
        logic [7:0] a0;
        i_ibh_ctrl_model.send_term();
        wait_bit(0, 1'b1, 6);
        eng_pulse(5'h01);
        eng_pulse(5'h02);
        wait_bit(4, 1'b1, 2);
        eng_pulse(5'h10);
        repeat (4) @(negedge clk);
        chk(fmt_cnt, 8'h00);
        a0 = auto_cnt;
        i_ibh_ctrl_model.set_talk(1'b1);
        wait_bit(5, 1'b1, 6);
        i_ibh_ctrl_model.take_bytes(2);
        i_ibh_ctrl_model.set_talk(1'b0);
        repeat (4) @(negedge clk);
        i_ibh_ctrl_model.set_talk(1'b1);
        repeat (6) @(negedge clk);
        chk(fmt_cnt, 8'h01);
        chk(auto_cnt, a0);
        i_ibh_ctrl_model.take_bytes(2);
        i_ibh_ctrl_model.set_talk(1'b0);
        // Terminator byte taken once unaddressed ends the response
        i_ibh_ctrl_model.take_bytes(1);
        repeat (4) @(negedge clk);
        i_ibh_ctrl_model.set_talk(1'b1);
        wait_bit(6, 1'b1, 6);
        @(negedge clk);
        chk({7'h00, auto_rd}, 8'h00);
        i_ibh_ctrl_model.set_talk(1'b0);
    endtask : t_query
    // Clears drop hold-off and pending query
    task automatic t_clear();
        logic [5:0] kinds [2] = '{6'h10, 6'h20};
        foreach (kinds[k]) begin
            i_ibh_ctrl_model.send_term();
            wait_bit(0, 1'b1, 6);
            eng_pulse(5'h01);
            eng_pulse(5'h02);
            i_ibh_ctrl_model.set_cmd(kinds[k]);
            wait_bit(8, 1'b1, 6);
            wait_bit(0, 1'b0, 6);
            chk({7'h00, mav}, 8'h00);
            i_ibh_ctrl_model.set_cmd(6'h00);
            wait_bit(8, 1'b0, 6);
        end
    endtask : t_clear
    // Remote, lockout, go-to-local, local key
    task automatic key();
        @(negedge clk);
        lkey = 1'b1;
        repeat (4) @(negedge clk);
        lkey = 1'b0;
        repeat (4) @(negedge clk);
    endtask : key
    task automatic t_remote();
        i_ibh_ctrl_model.set_cmd(6'h01);
        i_ibh_ctrl_model.send_term();
        wait_bit(9, 1'b1, 8);
        eng_pulse(5'h10);
        i_ibh_ctrl_model.set_cmd(6'h05);
        wait_bit(10, 1'b1, 6);
        key();
        chk({7'h00, remote_indicator}, 8'h01);
        i_ibh_ctrl_model.set_cmd(6'h03);
        wait_bit(10, 1'b0, 6);
        chk({7'h00, remote_indicator}, 8'h01);
        key();
        chk({7'h00, remote_indicator}, 8'h00);
        i_ibh_ctrl_model.set_cmd(6'h00);
    endtask : t_remote
    // Service request and serial poll
    task automatic t_srq();
        @(negedge clk);
        rqs = 1'b1;
        wait_bit(3, 1'b1, 4);
        i_ibh_ctrl_model.set_poll(1'b1);
        wait_bit(3, 1'b0, 6);
        i_ibh_ctrl_model.set_poll(1'b0);
        rqs = 1'b0;
        repeat (4) @(negedge clk);
    endtask : t_srq
    // Reset, scenarios, verdict
    initial begin
        nrst = 1'b0;
        lkey = 1'b0;
        nd_en = 1'b0;
        nd_wr = 1'b0;
        rqs = 1'b0;
        eng = '0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chk({5'h00, opt, ndac, nrfd}, 8'h00);
        t_release();
        t_ndac();
        t_query();
        t_clear();
        t_remote();
        t_srq();
        chk(ind_bad, 8'h00);
        test_done();
    end
    // Watchdog
    initial begin
        #2000000;
        bad_count++;
        test_done();
    end
endmodule : instrument_bus_holdoff_talk_logic_tb
